// ===== include/sbrg_pkg.sv
package sbrg_pkg;
  // register offsets on the plain register port
  localparam logic [2:0] SBRG_OFF_DIV_LOW  = 3'h0;
  localparam logic [2:0] SBRG_OFF_DIV_HIGH = 3'h1;
  localparam logic [2:0] SBRG_OFF_BAUD_CTL = 3'h2;
  localparam logic [2:0] SBRG_OFF_TX_STAT  = 3'h3;
  localparam logic [2:0] SBRG_OFF_RX_STAT  = 3'h4;
  // field positions
  localparam int SBRG_BIT_RX_IDLE   = 6;  // baud_control, read only
  localparam int SBRG_BIT_WIDE      = 3;  // baud_control
  localparam int SBRG_BIT_SYNC_MODE = 4;  // transmit_status_control
  localparam int SBRG_BIT_HIGH_SPD  = 2;  // transmit_status_control
  // writable mask: unimplemented baud_control bits read as zero; the status registers keep every written bit
  localparam logic [7:0] SBRG_BAUD_CTL_WMASK = 8'h1b;
  localparam logic [7:0] SBRG_RST_BYTE       = 8'h00;
  // prescale terminal counts: divide by 64, 16 and 4
  localparam logic [5:0] SBRG_PRE_64 = 6'h3f;
  localparam logic [5:0] SBRG_PRE_16 = 6'h0f;
  localparam logic [5:0] SBRG_PRE_4  = 6'h03;
endpackage : sbrg_pkg

// ===== include/sbrg_cfg_if.sv
`timescale 1ns/100ps
`default_nettype none
// configuration passed from the register file to the rate counter
interface sbrg_cfg_if;
  logic [15:0] divisor;
  logic [5:0]  pre_tc;
  logic        wide;
  logic        restart;
  modport regs (output divisor, output pre_tc, output wide, output restart);
  modport timer (input divisor, input pre_tc, input wide, input restart);
endinterface : sbrg_cfg_if
`default_nettype wire

// ===== design/sbrg_timer.sv
`timescale 1ns/100ps
`default_nettype none
// free-running divider: prescale stage then divisor counter
module sbrg_timer
  import sbrg_pkg::*;
(
  input  wire logic   core_clk_i,
  input  wire logic   sys_rst_i,
  sbrg_cfg_if.timer   cfg,
  output logic        tick_o
);
  logic [5:0]  pre_r,  pre_nxt;
  logic [15:0] cnt_r,  cnt_nxt;
  logic        tick_r, tick_nxt;
  logic [15:0] limit;

  // 8-bit counting uses only the low divisor byte
  assign limit = cfg.wide ? cfg.divisor : {8'h00, cfg.divisor[7:0]};

  // count up freely; a divisor write restarts from zero at once
  always_comb begin
    pre_nxt  = pre_r + 6'h01;
    cnt_nxt  = cnt_r;
    tick_nxt = 1'b0;
    if (cfg.restart) begin
      pre_nxt = 6'h00;
      cnt_nxt = 16'h0000;
    end else if (pre_r >= cfg.pre_tc) begin
      pre_nxt = 6'h00;
      if (cnt_r >= limit) begin
        cnt_nxt  = 16'h0000;
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pre_r  <= 6'h00;
      cnt_r  <= 16'h0000;
      tick_r <= 1'b0;
    end else begin
      pre_r  <= pre_nxt;
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end
  assign tick_o = tick_r;

  // a restart always pulls the counters to zero
  a_restart_clears: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    cfg.restart |=> (cnt_r == 16'h0000) && (pre_r == 6'h00) && !tick_r) else $error("restart did not clear");
  // a tick marks the wrap of both stages, so both stand at zero beside it
  a_tick_at_limit: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    tick_r |-> (cnt_r == 16'h0000) && (pre_r == 6'h00)) else $error("tick off the wrap");
  // the shortest period is four clocks, so no tick follows another within three
  a_tick_spacing: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    tick_r |=> (!tick_r) [*3]) else $error("ticks too close");
endmodule : sbrg_timer
`default_nettype wire

// ===== design/sbrg_top.sv
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/100ps
`default_nettype none
// Function
// - one dedicated rate timer counts in 8 or 16 bits for async and sync serial use.
// - after reset it counts in 8 bits; setting the wide-divider select switches to 16 bits.
// - the timer runs freely with period set by divisor n from the high and low bytes.
// - async divides by 64(n+1) with both bits clear and 16(n+1) with wide set, high-speed clear.
// - sync ignores high-speed and divides by 4(n+1) in either width.
// - any write to either divisor byte clears the timer at once.
module sbrg_top
  import sbrg_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic       rx_idle_i,
  output logic      [7:0] rdata_o,
  output logic            tick_o,
  output logic            sync_mode_o
);
  logic [7:0] div_low_r,  div_low_nxt;
  logic [7:0] div_high_r, div_high_nxt;
  logic [7:0] baud_ctl_r, baud_ctl_nxt;
  logic [7:0] tx_stat_r,  tx_stat_nxt;
  logic [7:0] rx_stat_r,  rx_stat_nxt;
  logic [7:0] rdata_r,    rdata_nxt;
  logic       idle_m_r,   idle_r;
  logic       wide, high_spd, sync_m;
  logic [5:0] pre_sel;
  logic [23:0] gap_r,      gap_nxt;
  logic        gap_ok_r,   gap_ok_nxt;
  logic [23:0] want_per;

  sbrg_cfg_if cfg_bus ();

  // prescale choice from mode bits
  function automatic logic [5:0] sbrg_pre(input logic s, input logic w, input logic h);
    if (s)
      sbrg_pre = SBRG_PRE_4;
    else if (!w && !h)
      sbrg_pre = SBRG_PRE_64;
    else if (w && h)
      sbrg_pre = SBRG_PRE_4;
    else
      sbrg_pre = SBRG_PRE_16;
  endfunction : sbrg_pre

  // bit period in clocks straight from the rate formulas, kept apart from
  // sbrg_pre so the period check does not just echo the prescale choice
  function automatic logic [23:0] sbrg_period(input logic        s,
                                              input logic        w,
                                              input logic        h,
                                              input logic [15:0] d);
    logic [23:0] n_plus;
    logic [23:0] mult;
    // 8-bit counting sees only the low byte of n
    if (w) begin
      n_plus = {8'h00, d} + 24'h000001;
    end else begin
      n_plus = {16'h0000, d[7:0]} + 24'h000001;
    end
    // sync ignores the high-speed bit; async picks from both selects
    if (s) begin
      mult = {18'h00000, SBRG_PRE_4} + 24'h000001;
    end else if (w) begin
      mult = h ? {18'h00000, SBRG_PRE_4} + 24'h000001 : {18'h00000, SBRG_PRE_16} + 24'h000001;
    end else begin
      mult = h ? {18'h00000, SBRG_PRE_16} + 24'h000001 : {18'h00000, SBRG_PRE_64} + 24'h000001;
    end
    sbrg_period = n_plus * mult;
  endfunction : sbrg_period

  // idle flag arrives from the receiver pin domain
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      idle_m_r <= 1'b1;
      idle_r   <= 1'b1;
    end else begin
      idle_m_r <= rx_idle_i;
      idle_r   <= idle_m_r;
    end
  end

  // register writes and read data
  always_comb begin
    div_low_nxt  = div_low_r;
    div_high_nxt = div_high_r;
    baud_ctl_nxt = baud_ctl_r;
    tx_stat_nxt  = tx_stat_r;
    rx_stat_nxt  = rx_stat_r;
    rdata_nxt    = 8'h00;
    if (wr_i) begin
      unique case (addr_i)
        SBRG_OFF_DIV_LOW:  div_low_nxt  = wdata_i;
        SBRG_OFF_DIV_HIGH: div_high_nxt = wdata_i;
        SBRG_OFF_BAUD_CTL: baud_ctl_nxt = wdata_i & SBRG_BAUD_CTL_WMASK;
        SBRG_OFF_TX_STAT:  tx_stat_nxt  = wdata_i;
        SBRG_OFF_RX_STAT:  rx_stat_nxt  = wdata_i;
        default:           ;
      endcase
    end
    if (rd_i) begin
      unique case (addr_i)
        SBRG_OFF_DIV_LOW:  rdata_nxt = div_low_r;
        SBRG_OFF_DIV_HIGH: rdata_nxt = div_high_r;
        SBRG_OFF_BAUD_CTL: begin
          rdata_nxt = baud_ctl_r;
          rdata_nxt[SBRG_BIT_RX_IDLE] = idle_r; // live receiver status
        end
        SBRG_OFF_TX_STAT:  rdata_nxt = tx_stat_r;
        SBRG_OFF_RX_STAT:  rdata_nxt = rx_stat_r;
        default:           rdata_nxt = 8'h00; // unmapped reads zero
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      div_low_r  <= SBRG_RST_BYTE;
      div_high_r <= SBRG_RST_BYTE;
      baud_ctl_r <= SBRG_RST_BYTE;
      tx_stat_r  <= SBRG_RST_BYTE;
      rx_stat_r  <= SBRG_RST_BYTE;
      rdata_r    <= 8'h00;
    end else begin
      div_low_r  <= div_low_nxt;
      div_high_r <= div_high_nxt;
      baud_ctl_r <= baud_ctl_nxt;
      tx_stat_r  <= tx_stat_nxt;
      rx_stat_r  <= rx_stat_nxt;
      rdata_r    <= rdata_nxt;
    end
  end
  assign rdata_o = rdata_r;

  // mode decode feeding the shared counter
  assign wide     = baud_ctl_r[SBRG_BIT_WIDE];
  assign high_spd = tx_stat_r[SBRG_BIT_HIGH_SPD];
  assign sync_m   = tx_stat_r[SBRG_BIT_SYNC_MODE];
  assign pre_sel  = sbrg_pre(sync_m, wide, high_spd);
  assign sync_mode_o = sync_m;

  // restart fires in the write cycle so the new divisor starts clean;
  // the divisor change lands at the same edge as the clear
  assign cfg_bus.divisor = {div_high_r, div_low_r};
  assign cfg_bus.pre_tc  = pre_sel;
  assign cfg_bus.wide    = wide;
  assign cfg_bus.restart = wr_i && (addr_i == SBRG_OFF_DIV_LOW || addr_i == SBRG_OFF_DIV_HIGH);

  sbrg_timer u_timer (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .cfg        (cfg_bus.timer),
    .tick_o     (tick_o)
  );

  // helper for a_period_match: clocks since the last tick, and whether any
  // register write fell inside that stretch, since a write may move the period
  always_comb begin
    gap_nxt    = gap_r + 24'h000001;
    gap_ok_nxt = gap_ok_r && !wr_i;
    if (tick_o) begin
      gap_nxt    = 24'h000001;
      gap_ok_nxt = !wr_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      gap_r    <= 24'h000000;
      gap_ok_r <= 1'b0; // the first period after reset is not measured
    end else begin
      gap_r    <= gap_nxt;
      gap_ok_r <= gap_ok_nxt;
    end
  end
  assign want_per = sbrg_period(sync_m, wide, high_spd, cfg_bus.divisor);

  // sync mode always uses the divide-by-4 prescale
  a_sync_div_four: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    sync_m |-> (pre_sel == SBRG_PRE_4)) else $error("sync prescale wrong");
  // async slow mode uses divide-by-64
  a_async_slow_div: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (!sync_m && !wide && !high_spd) |-> (pre_sel == SBRG_PRE_64)) else $error("async 64 wrong");
  // async wide or high-speed alone uses divide-by-16
  a_async_mid_div: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (!sync_m && (wide != high_spd)) |-> (pre_sel == SBRG_PRE_16)) else $error("async 16 wrong");
  // async wide and high-speed uses divide-by-4
  a_async_fast_div: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (!sync_m && wide && high_spd) |-> (pre_sel == SBRG_PRE_4)) else $error("async 4 wrong");
  // a high divisor byte write is stored and, as a restart, gives no tick in the next cycle
  a_div_write_restart: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (wr_i && addr_i == SBRG_OFF_DIV_HIGH) |=> (cfg_bus.divisor[15:8] == $past(wdata_i)) && !tick_o)
    else $error("divisor write lost");
  // wide bit follows a write to the baud control register
  a_wide_follows: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (wr_i && addr_i == SBRG_OFF_BAUD_CTL) |=> (wide == $past(wdata_i[SBRG_BIT_WIDE])))
    else $error("wide select not stored");
  // with no write since the last tick, tick spacing is the bit period of the formulas
  a_period_match: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (tick_o && gap_ok_r) |-> (gap_r == want_per)) else $error("bit period wrong");
  // leaving reset the timer is in 8-bit async mode with a zero divisor
  a_reset_narrow: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    $fell(sys_rst_i) |-> !wide && !sync_m && !high_spd && (cfg_bus.divisor == {SBRG_RST_BYTE, SBRG_RST_BYTE}))
    else $error("reset mode wrong");
  // the second idle synchroniser stage takes the first stage's value one clock later
  a_idle_two_stage: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !$past(sys_rst_i) |-> (idle_r == $past(idle_m_r))) else $error("idle sync skipped a stage");
  // read data stand only in the cycle after a read strobe
  a_rdata_quiet: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !rd_i |=> (rdata_o == 8'h00)) else $error("read data outside read");
endmodule : sbrg_top
`default_nettype wire

// ===== dv/test_serial_baud_rate_generator.sv
`timescale 1ns/100ps
`default_nettype none
`define check_eq(nm, exp, got) begin checked++; if ((got) !== (exp)) begin err_count++; \
  $display("unexpected %s: expected %0h seen %0h", nm, exp, got); end end
module test_serial_baud_rate_generator
  import sbrg_pkg::*;
;
  typedef struct packed {logic [7:0] tx; logic [7:0] bc; logic [7:0] hi; logic [7:0] lo; int per;} sbrg_row_s;
  logic       core_clk_i = 1'b0;
  logic       sys_rst_i  = 1'b1;
  logic [2:0] addr_i     = 3'h0;
  logic [7:0] wdata_i    = 8'h00;
  logic       wr_i       = 1'b0;
  logic       rd_i       = 1'b0;
  logic       rx_idle_i  = 1'b1;
  logic [7:0] rdata_o;
  logic       tick_o;
  logic       sync_mode_o;
  int         err_count  = 0;
  int         checked    = 0;
  int         cycles     = 0;
  int         per;
  logic [7:0] rd_val;
  // one row per mode: control bytes, divisor, expected period in clocks
  sbrg_row_s  rows [6] = '{
    '{8'h00, 8'h00, 8'h00, 8'h02, 192}, '{8'h04, 8'h00, 8'h01, 8'h03, 64},
    '{8'h00, 8'h08, 8'h01, 8'h00, 4112}, '{8'h04, 8'h08, 8'h00, 8'h09, 40},
    '{8'h14, 8'h00, 8'h01, 8'h07, 32}, '{8'h10, 8'h08, 8'h01, 8'h02, 1036}};

  sbrg_top dut_u (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rx_idle_i(rx_idle_i), .rdata_o(rdata_o), .tick_o(tick_o), .sync_mode_o(sync_mode_o));

  always #4 core_clk_i = ~core_clk_i;

  // hang guard: the longest row plus the restart test stay well below this
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize

  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask : reg_wr

  // read data stand only in the cycle after the strobe, so sample at the edge ending it
  task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    @(posedge core_clk_i);
    d = rdata_o;
  endtask : reg_rd

  // edges from now until tick is seen, bounded so a dead timer cannot hang here
  task automatic to_tick(output int n);
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (tick_o !== 1'b1 && n < 20000);
  endtask : to_tick

  initial begin
    repeat (16) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    // reset state: idle flag visible, other baud control bits and both divisor bytes clear, default divide
    reg_rd(SBRG_OFF_BAUD_CTL, rd_val); `check_eq("baud_ctl rst", 8'h40, rd_val)
    reg_rd(SBRG_OFF_DIV_LOW, rd_val); `check_eq("div_low rst", SBRG_RST_BYTE, rd_val)
    reg_rd(SBRG_OFF_DIV_HIGH, rd_val); `check_eq("div_high rst", SBRG_RST_BYTE, rd_val)
    to_tick(per); to_tick(per); `check_eq("rst period", 64, per)
    // masked control bits, idle flag tracking, unmapped place
    reg_wr(SBRG_OFF_BAUD_CTL, 8'hff);
    reg_rd(SBRG_OFF_BAUD_CTL, rd_val); `check_eq("baud_ctl mask", 8'h5b, rd_val)
    rx_idle_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    reg_rd(SBRG_OFF_BAUD_CTL, rd_val); `check_eq("idle flag", 8'h1b, rd_val)
    rx_idle_i <= 1'b1;
    reg_wr(3'h5, 8'ha5);
    reg_rd(3'h5, rd_val); `check_eq("unmapped", 8'h00, rd_val)
    // every mode: control first, divisor last so the timer restarts
    foreach (rows[i]) begin
      reg_wr(SBRG_OFF_TX_STAT, rows[i].tx);
      reg_wr(SBRG_OFF_BAUD_CTL, rows[i].bc);
      reg_wr(SBRG_OFF_DIV_HIGH, rows[i].hi);
      reg_wr(SBRG_OFF_DIV_LOW, rows[i].lo);
      reg_rd(SBRG_OFF_DIV_HIGH, rd_val); `check_eq("div_high", rows[i].hi, rd_val)
      `check_eq("sync_mode", rows[i].tx[4], sync_mode_o)
      to_tick(per); to_tick(per); `check_eq("period", rows[i].per, per)
    end
    // divisor rewrite mid-count: new rate must not wait out the long old count
    reg_wr(SBRG_OFF_TX_STAT, 8'h00);
    reg_wr(SBRG_OFF_BAUD_CTL, 8'h00);
    reg_wr(SBRG_OFF_DIV_HIGH, 8'h00);
    reg_wr(SBRG_OFF_DIV_LOW, 8'hc8);
    to_tick(per);
    repeat (100) @(posedge core_clk_i);
    reg_wr(SBRG_OFF_DIV_LOW, 8'h00);
    to_tick(per); `check_eq("restart", 1'b1, (per >= 62 && per <= 66))
    to_tick(per); `check_eq("restart period", 64, per)
    // high byte write alone also restarts
    reg_wr(SBRG_OFF_DIV_LOW, 8'hc8);
    repeat (100) @(posedge core_clk_i);
    reg_wr(SBRG_OFF_DIV_HIGH, 8'h00);
    to_tick(per); `check_eq("restart high", 1'b1, (per >= 12860 && per <= 12868))
    // mid-run reset out of a sync, wide setup: registers clear and the default divide is back
    reg_wr(SBRG_OFF_TX_STAT, 8'h14);
    reg_wr(SBRG_OFF_BAUD_CTL, 8'h08);
    reg_wr(SBRG_OFF_DIV_HIGH, 8'h01);
    sys_rst_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    `check_eq("sync_mode rst", 1'b0, sync_mode_o)
    reg_rd(SBRG_OFF_TX_STAT, rd_val); `check_eq("tx_stat rst", SBRG_RST_BYTE, rd_val)
    reg_rd(SBRG_OFF_BAUD_CTL, rd_val); `check_eq("baud_ctl mid rst", 8'h40, rd_val)
    reg_rd(SBRG_OFF_DIV_HIGH, rd_val); `check_eq("div_high mid rst", SBRG_RST_BYTE, rd_val)
    to_tick(per); to_tick(per); `check_eq("mid rst period", 64, per)
    summarize();
  end
endmodule : test_serial_baud_rate_generator
`default_nettype wire
